// ==== design/dmc_config.sv ====
// Purpose: Mode and extended mode configuration decode of a DDR2 device
// Assumes: Command pins sampled on clk_sys; odt_pin crosses from the pins
// Notes: Read and write launches are strobes the datapath uses to start bursts
`timescale 1ns/100ps
`default_nettype none
module dmc_config
  import dmc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic load_mode,
  input wire logic [1:0] bank_sel,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic read_cmd,
  input wire logic write_cmd,
  input wire logic self_refresh_enter,
  input wire logic self_refresh_exit,
  input wire logic power_down,
  input wire logic odt_pin,
  input wire logic x8_config,
  output logic dll_enable,
  output logic dll_reset,
  output logic drive_reduced,
  output logic strobe_n_enable,
  output logic dup_strobe_enable,
  output logic dup_strobe_n_enable,
  output logic outputs_enable,
  output logic [1:0] termination_value,
  output logic termination_on,
  output logic [LAT_W-1:0] read_latency,
  output logic [LAT_W-1:0] write_latency,
  output logic [2:0] ocd_field,
  output logic read_data_start,
  output logic write_data_start,
  output logic read_internal,
  output logic write_internal
);
  logic [ADDR_W-1:0] extended_mode_config;
  logic [2:0] read_latency_field;
  dmc_pstate_type pstate;
  dmc_pstate_type next_pstate;
  logic odt_sync;
  logic rd_int_w;
  logic wr_int_w;
  logic rd_start_w;
  logic wr_start_w;

  // Field decode from the held register
  wire dll_disable_bit = extended_mode_config[POS_DLL];
  wire drive_strength_bit = extended_mode_config[POS_DRIVE];
  wire termination_select_low = extended_mode_config[POS_TERM_LO];
  wire termination_select_high = extended_mode_config[POS_TERM_HI];
  wire [2:0] additive_latency_field = extended_mode_config[POS_AL_HI:POS_AL_LO];
  wire strobe_complement_disable = extended_mode_config[POS_STROBE_N];
  wire duplicate_strobe_enable = extended_mode_config[POS_DUP];
  wire output_disable_bit = extended_mode_config[POS_OUT_DIS];

  wire load_ext = load_mode && (bank_sel == BANK_EXT);
  wire load_mr = load_mode && (bank_sel == BANK_MODE);
  wire [1:0] term_code = {termination_select_low, termination_select_high};
  wire [1:0] next_term = (term_code == 2'h2) ? TERM_75 :
                         (term_code == 2'h1) ? TERM_150 :
                         (term_code == 2'h3) ? TERM_50 : TERM_OFF;
  // Reserved codes clamp into range rather than producing odd latencies
  wire [2:0] cl_eff = (read_latency_field < RL_MIN) ? RL_MIN : read_latency_field;
  wire [2:0] al_eff = (additive_latency_field > AL_MAX) ? AL_MAX : additive_latency_field;
  wire [LAT_W-1:0] next_rl = {1'b0, al_eff} + {1'b0, cl_eff};
  wire [LAT_W-1:0] next_wl = next_rl - 4'h1;
  wire odt_state_ok = (pstate != DMC_SELF);
  wire next_term_on = (next_term != TERM_OFF) && odt_sync && odt_state_ok;
  wire next_dll_en = !dll_disable_bit && (pstate != DMC_SELF);
  wire next_dll_rst = (load_mr && addr[POS_DLL_RESET]) ||
                      (pstate == DMC_SELF && self_refresh_exit);
  wire next_strobe_n = !strobe_complement_disable && !output_disable_bit;
  wire next_dup = duplicate_strobe_enable && x8_config && !output_disable_bit;
  wire next_dup_n = next_dup && !strobe_complement_disable;

  always_comb begin
    next_pstate = pstate;
    unique case (pstate)
      DMC_ACTIVE: begin
        if (self_refresh_enter) begin
          next_pstate = DMC_SELF;
        end else if (power_down) begin
          next_pstate = DMC_PDOWN;
        end
      end
      DMC_PDOWN: begin
        if (!power_down) begin
          next_pstate = DMC_ACTIVE;
        end
      end
      DMC_SELF: begin
        if (self_refresh_exit) begin
          next_pstate = DMC_ACTIVE;
        end
      end
      default: next_pstate = DMC_ACTIVE;
    endcase
  end

  dmc_sync3 u_odt_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .din(odt_pin),
    .dout(odt_sync)
  );

  // Commands are held for the additive latency before issuing internally
  dmc_delay u_al_rd (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .strobe_in(read_cmd),
    .delay({1'b0, al_eff}),
    .strobe_out(rd_int_w)
  );
  dmc_delay u_al_wr (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .strobe_in(write_cmd),
    .delay({1'b0, al_eff}),
    .strobe_out(wr_int_w)
  );
  // Output launch one edge early so the registered strobe lands on n + RL for reads and n + WL for writes
  dmc_delay u_rl (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .strobe_in(read_cmd),
    .delay(next_rl - 4'h1),
    .strobe_out(rd_start_w)
  );
  dmc_delay u_wl (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .strobe_in(write_cmd),
    .delay(next_wl - 4'h1),
    .strobe_out(wr_start_w)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      extended_mode_config <= EXT_RESET;
      read_latency_field <= RL_FIELD_RESET;
    end else if (ce) begin
      if (load_ext) begin
        extended_mode_config <= addr;
      end
      if (load_mr) begin
        read_latency_field <= addr[POS_RL_HI:POS_RL_LO];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pstate <= DMC_ACTIVE;
    end else if (ce) begin
      pstate <= next_pstate;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dll_enable <= 1'b0;
      dll_reset <= 1'b0;
      drive_reduced <= 1'b0;
      strobe_n_enable <= 1'b0;
      dup_strobe_enable <= 1'b0;
      dup_strobe_n_enable <= 1'b0;
      outputs_enable <= 1'b0;
      termination_value <= TERM_OFF;
      termination_on <= 1'b0;
      read_latency <= LAT_W_ZERO;
      write_latency <= LAT_W_ZERO;
      ocd_field <= 3'h0;
    end else if (ce) begin
      dll_enable <= next_dll_en;
      dll_reset <= next_dll_rst;
      drive_reduced <= drive_strength_bit;
      strobe_n_enable <= next_strobe_n;
      dup_strobe_enable <= next_dup;
      dup_strobe_n_enable <= next_dup_n;
      outputs_enable <= !output_disable_bit;
      termination_value <= next_term;
      termination_on <= next_term_on;
      read_latency <= next_rl;
      write_latency <= next_wl;
      ocd_field <= extended_mode_config[POS_OCD_HI:POS_OCD_LO];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      read_data_start <= 1'b0;
      write_data_start <= 1'b0;
      read_internal <= 1'b0;
      write_internal <= 1'b0;
    end else if (ce) begin
      read_data_start <= rd_start_w && !output_disable_bit;
      write_data_start <= wr_start_w;
      read_internal <= rd_int_w;
      write_internal <= wr_int_w;
    end
  end

  AST_EXT_CAPTURE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && load_ext) |=> (extended_mode_config == $past(addr)))
    else $error("extended register not captured");
  AST_EXT_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && !load_ext) |=> $stable(extended_mode_config))
    else $error("extended register changed without load");
  AST_DLL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && pstate == DMC_ACTIVE && next_pstate == DMC_ACTIVE) |=>
      (dll_enable == !$past(dll_disable_bit)))
    else $error("dll enable does not follow bit zero");
  AST_SELF_DLL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && pstate == DMC_SELF) |=> !dll_enable)
    else $error("dll on during self refresh");
  AST_SELF_EXIT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && pstate == DMC_SELF && self_refresh_exit) |=> dll_reset)
    else $error("dll not reset on self refresh exit");
  AST_DUP_N: assert property (@(posedge clk_sys) disable iff (!rst_b)
    dup_strobe_n_enable |-> (dup_strobe_enable && strobe_n_enable))
    else $error("duplicate complement without both enables");
  AST_OUT_DIS: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && output_disable_bit) |=> (!outputs_enable && !strobe_n_enable && !dup_strobe_enable))
    else $error("outputs enabled while disabled");
  AST_WL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (read_latency != LAT_W_ZERO) |-> (write_latency == read_latency - 4'h1))
    else $error("write latency not read latency minus one");
  AST_RL_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (read_latency != LAT_W_ZERO) |-> (read_latency >= 4'h3 && read_latency <= 4'hd))
    else $error("read latency out of range");
  AST_TERM_SELF: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && pstate == DMC_SELF) |=> !termination_on)
    else $error("termination on in self refresh");
  AST_RD_AL0: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && read_cmd && al_eff == 3'h0 && read_latency_field == 3'h3 && !output_disable_bit
      && !load_mode) ##1 ce [*3] |-> read_data_start)
    else $error("read data not at n plus m");
  AST_RD_AL2: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && read_cmd && al_eff == 3'h2 && read_latency_field == 3'h5 && !output_disable_bit
      && !load_mode) ##1 ce [*7] |-> read_data_start)
    else $error("read data not at n plus read latency");
  AST_WR_AL2: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && write_cmd && al_eff == 3'h2 && read_latency_field == 3'h5 && !load_mode)
      ##1 ce [*6] |-> write_data_start)
    else $error("write data not at n plus write latency");
  AST_MR_CAPTURE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && load_mr) |=> (read_latency_field == $past(addr[POS_RL_HI:POS_RL_LO])))
    else $error("read latency field not captured");
  AST_BANK_IGNORE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && load_mode && bank_sel[1]) |=> ($stable(extended_mode_config) && $stable(read_latency_field)))
    else $error("registers changed by a load to another bank");
  AST_RL_SUM: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ce |=> (read_latency == $past({1'b0, al_eff} + {1'b0, cl_eff})))
    else $error("read latency not additive plus field");
  AST_INT_AL0: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && read_cmd && al_eff == 3'h0) |=> read_internal)
    else $error("read not issued internally without additive latency");
  AST_AL_INT2: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && read_cmd && al_eff == 3'h2 && !load_mode) ##1 ce [*3] |-> read_internal)
    else $error("read not held for the additive latency");
  AST_WR_INT_AL0: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && write_cmd && al_eff == 3'h0) |=> write_internal)
    else $error("write not issued internally without additive latency");
  AST_RD_SUPPRESS: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && output_disable_bit) |=> !read_data_start)
    else $error("read data launched while outputs disabled");
  AST_OUT_EN: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && !output_disable_bit) |=> outputs_enable)
    else $error("outputs disabled without the disable bit");
  AST_DRIVE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ce |=> (drive_reduced == $past(drive_strength_bit)))
    else $error("drive strength does not follow its bit");
  AST_STROBE_N_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && strobe_complement_disable) |=> (!strobe_n_enable && !dup_strobe_n_enable))
    else $error("complement strobe on while disabled");
  AST_STROBE_N_ON: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && !strobe_complement_disable && !output_disable_bit) |=> strobe_n_enable)
    else $error("complement strobe off while enabled");
  AST_DUP_X8: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && !x8_config) |=> (!dup_strobe_enable && !dup_strobe_n_enable))
    else $error("duplicate strobe on outside x8");
  AST_DUP_ON: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && duplicate_strobe_enable && x8_config && !output_disable_bit) |=> dup_strobe_enable)
    else $error("duplicate strobe off while enabled");
  AST_TERM_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && term_code == 2'h0) |=> (termination_value == TERM_OFF && !termination_on))
    else $error("termination on while off in register");
  AST_TERM_75: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && term_code == 2'h2) |=> (termination_value == TERM_75))
    else $error("termination code low bit not 75 ohms");
  AST_TERM_150: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && term_code == 2'h1) |=> (termination_value == TERM_150))
    else $error("termination code high bit not 150 ohms");
  AST_TERM_50: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && term_code == 2'h3) |=> (termination_value == TERM_50))
    else $error("termination code both bits not 50 ohms");
  AST_TERM_FOLLOW: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && odt_state_ok && next_term != TERM_OFF) |=> (termination_on == $past(odt_sync)))
    else $error("termination does not follow its control input");
  AST_PDOWN_TERM: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && pstate == DMC_PDOWN && next_term != TERM_OFF && odt_sync) |=> termination_on)
    else $error("termination off in power-down with control high");
  AST_SELF_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && pstate == DMC_ACTIVE && self_refresh_enter) ##1 ce |=> !dll_enable)
    else $error("dll still on after self refresh entry");
  // Clock enable low must freeze every held setting
  AST_CE_FREEZE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !ce |=> ($stable(extended_mode_config) && $stable(read_latency_field) && $stable(pstate)))
    else $error("state changed with clock enable low");
endmodule
`default_nettype wire

// ==== design/dmc_pkg.sv ====
// Purpose: Shared constants for the mode and extended mode configuration decode
// Assumes: Load-mode command decoded from sampled command pins on clk_sys
// Notes: Bit positions follow the address pins that carry each field
package dmc_pkg;
  localparam int ADDR_W = 13;
  localparam logic [1:0] BANK_MODE = 2'h0;
  localparam logic [1:0] BANK_EXT = 2'h1;
  localparam int POS_DLL = 0;
  localparam int POS_DRIVE = 1;
  localparam int POS_TERM_LO = 2;
  localparam int POS_AL_LO = 3;
  localparam int POS_AL_HI = 5;
  localparam int POS_TERM_HI = 6;
  localparam int POS_OCD_LO = 7;
  localparam int POS_OCD_HI = 9;
  localparam int POS_STROBE_N = 10;
  localparam int POS_DUP = 11;
  localparam int POS_OUT_DIS = 12;
  localparam int POS_RL_LO = 4;
  localparam int POS_RL_HI = 6;
  localparam int POS_DLL_RESET = 8;
  // Extended register after reset: DLL on, full drive, termination off, AL 0
  localparam logic [12:0] EXT_RESET = 13'h0000;
  // Read latency field after reset selects 3 clocks
  localparam logic [2:0] RL_FIELD_RESET = 3'h3;
  localparam logic [2:0] RL_MIN = 3'h3;
  localparam logic [2:0] RL_MAX = 3'h7;
  localparam logic [2:0] AL_MAX = 3'h6;
  localparam logic [3:0] LAT_W_ZERO = 4'h0;
  localparam int LAT_W = 4;
  localparam int PIPE_LEN = 14;
  // Termination ohm codes reported on termination_value
  localparam logic [1:0] TERM_OFF = 2'h0;
  localparam logic [1:0] TERM_75 = 2'h1;
  localparam logic [1:0] TERM_150 = 2'h2;
  localparam logic [1:0] TERM_50 = 2'h3;
  typedef enum logic [1:0] {DMC_ACTIVE, DMC_PDOWN, DMC_SELF} dmc_pstate_type;
endpackage

// ==== design/dmc_sync3.sv ====
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Input is asynchronous to clk_sys
// Notes: Output changes once stage two and stage three agree
`timescale 1ns/100ps
`default_nettype none
module dmc_sync3
  import dmc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  logic s1;
  logic s2;
  logic s3;
  wire agree = (s2 == s3);
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else if (ce) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (agree) begin
        dout <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/dmc_delay.sv ====
// Purpose: Variable-length delay line for command strobes
// Assumes: Delay selected per cycle, stable while a strobe is in flight
// Notes: Delay of zero passes the strobe combinationally
`timescale 1ns/100ps
`default_nettype none
module dmc_delay
  import dmc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic strobe_in,
  input wire logic [LAT_W-1:0] delay,
  output logic strobe_out
);
  // Flops and the live input kept apart so each tap has one clean driver
  logic [PIPE_LEN:1] taps_q;
  wire [PIPE_LEN:0] taps = {taps_q, strobe_in};
  genvar i;
  generate
    for (i = 1; i <= PIPE_LEN; i++) begin : g_tap
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          taps_q[i] <= 1'b0;
        end else if (ce) begin
          taps_q[i] <= taps[i-1];
        end
      end
    end
  endgenerate
  assign strobe_out = taps[delay];
endmodule
`default_nettype wire

// ==== testbench/dmc_ctrl_model.sv ====
// Purpose: Controller model that issues load-mode commands to the configuration decode
// Assumes: Caller enters load_reg 1 ns after a rising edge of clk_sys
// Notes: Released address and bank pins show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module dmc_ctrl_model
  import dmc_pkg::*;
#(
  parameter int MRD_CYCLES = 2
)(
  input wire logic clk_sys,
  output logic load_mode,
  output logic [1:0] bank_sel,
  output logic [ADDR_W-1:0] addr
);
  initial begin
    load_mode = 1'b0;
    bank_sel = 2'h3;
    addr = 13'h0000;
  end
  task automatic load_reg(input logic [1:0] bank, input logic [ADDR_W-1:0] value);
    load_mode = 1'b1;
    bank_sel = bank;
    addr = value;
    @(posedge clk_sys);
    #1;
    load_mode = 1'b0;
    bank_sel = ~bank;
    addr = ~value;
    // No further command until the mode-set delay has run out
    repeat (MRD_CYCLES) @(posedge clk_sys);
    #1;
  endtask
endmodule
`default_nettype wire

// ==== testbench/ddr2_ext_mode_config_tb.sv ====
// Purpose: Self-checking bench for the mode and extended mode configuration decode
// Assumes: Inputs change 1 ns after the rising edge of clk_sys
// Notes: Strobe timing is checked by a watcher against queued cycle numbers
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module ddr2_ext_mode_config_tb
  import dmc_pkg::*;
();
  logic clk_sys, rst_b, ce, read_cmd, write_cmd, sr_enter, sr_exit, power_down, odt_pin;
  logic x8_config, load_mode, dll_enable, dll_reset, drive_reduced, strobe_n_enable;
  logic dup_strobe_enable, dup_strobe_n_enable, outputs_enable, termination_on;
  logic read_data_start, write_data_start, read_internal, write_internal;
  logic [1:0] bank_sel, termination_value;
  logic [ADDR_W-1:0] addr;
  logic [LAT_W-1:0] read_latency, write_latency;
  logic [2:0] ocd_field;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int rq[$], wq[$], iq[$], jq[$];

  dmc_config u_dmc_config (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .load_mode(load_mode), .bank_sel(bank_sel),
    .addr(addr), .read_cmd(read_cmd), .write_cmd(write_cmd),
    .self_refresh_enter(sr_enter), .self_refresh_exit(sr_exit), .power_down(power_down),
    .odt_pin(odt_pin), .x8_config(x8_config), .dll_enable(dll_enable), .dll_reset(dll_reset),
    .drive_reduced(drive_reduced), .strobe_n_enable(strobe_n_enable),
    .dup_strobe_enable(dup_strobe_enable), .dup_strobe_n_enable(dup_strobe_n_enable),
    .outputs_enable(outputs_enable), .termination_value(termination_value),
    .termination_on(termination_on), .read_latency(read_latency),
    .write_latency(write_latency), .ocd_field(ocd_field), .read_data_start(read_data_start),
    .write_data_start(write_data_start), .read_internal(read_internal),
    .write_internal(write_internal)
  );
  dmc_ctrl_model u_dmc_ctrl_model (
    .clk_sys(clk_sys), .load_mode(load_mode), .bank_sel(bank_sel), .addr(addr)
  );

  initial begin
    clk_sys = 1'b0;
    // 25 MHz is not below the slow-clock limit, so refreshes need no precharge-all
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic take(ref int q[$]);
    int e;
    e = (q.size() > 0) ? q.pop_front() : -1;
    // A strobe launched at edge cyc is sampled by the datapath at the next edge
    `CHK(e, cyc + 1)
  endtask

  // Strobes are judged half a cycle after the edge that raised them
  always @(negedge clk_sys) begin
    if (read_data_start === 1'b1) take(rq);
    if (write_data_start === 1'b1) take(wq);
    if (read_internal === 1'b1) take(iq);
    if (write_internal === 1'b1) take(jq);
  end

  // Read at edge cyc+1, then write one edge later; idle long enough to drain
  task automatic rw(input int al, input int rl, input logic oe);
    read_cmd = 1'b1;
    if (oe) rq.push_back(cyc + 1 + rl);
    iq.push_back(cyc + 2 + al);
    step(1);
    read_cmd = 1'b0;
    write_cmd = 1'b1;
    wq.push_back(cyc + rl);
    jq.push_back(cyc + 2 + al);
    step(1);
    write_cmd = 1'b0;
    step(16);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #(40 * 5000);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    logic [ADDR_W-1:0] a;
    logic [1:0] tv;
    logic seen;
    int cl, al;
    {rst_b, read_cmd, write_cmd, sr_enter, sr_exit, power_down, odt_pin, x8_config} = '0;
    ce = 1'b1;
    void'($urandom(23));
    repeat (10) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    step(2);
    `CHK(dll_enable, 1'b1)
    `CHK(outputs_enable, 1'b1)
    `CHK(read_latency, 4'h3)
    `CHK(write_latency, 4'h2)
    `CHK(termination_value, TERM_OFF)
    // Calibration default during init: all three bits set, then cleared
    u_dmc_ctrl_model.load_reg(BANK_EXT, 13'h0380);
    `CHK(ocd_field, 3'h7)
    u_dmc_ctrl_model.load_reg(BANK_EXT, 13'h0000);
    `CHK(ocd_field, 3'h0)
    // Loop reset after enabling, then let it lock before any read
    u_dmc_ctrl_model.load_reg(BANK_MODE, 13'h0130);
    step(200);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      cl = 3 + i % 5;
      al = i % 7;
      // Calibration bits stay at their default of zero
      a = ADDR_W'($urandom) & 13'h1c47;
      a[5:3] = 3'(al);
      x8_config = 1'($urandom);
      power_down = 1'($urandom);
      tv = a[2] ? (a[6] ? TERM_50 : TERM_75) : (a[6] ? TERM_150 : TERM_OFF);
      // Early passes keep outputs on so the fixed-latency checks fire
      if (i < 3) a[12] = 1'b0;
      u_dmc_ctrl_model.load_reg(BANK_EXT, a);
      // Every loop enable is followed by a loop reset and the lock wait
      u_dmc_ctrl_model.load_reg(BANK_MODE, 13'(cl << 4) | {4'h0, ~a[0], 8'h00});
      if (!a[0]) step(200);
      `CHK(dll_enable, ~a[0])
      `CHK(drive_reduced, a[1])
      `CHK(strobe_n_enable, ~a[10] & ~a[12])
      `CHK(dup_strobe_enable, a[11] & x8_config & ~a[12])
      `CHK(dup_strobe_n_enable, a[11] & ~a[10] & x8_config & ~a[12])
      `CHK(ocd_field, 3'h0)
      `CHK(outputs_enable, ~a[12])
      `CHK(termination_value, tv)
      `CHK(read_latency, LAT_W'(al + cl))
      `CHK(write_latency, LAT_W'(al + cl - 1))
      step(8);
      odt_pin = 1'b1;
      step(6);
      `CHK(termination_on, tv != TERM_OFF)
      odt_pin = 1'b0;
      step(6);
      `CHK(termination_on, 1'b0)
      rw(al, al + cl, ~a[12]);
      u_dmc_ctrl_model.load_reg(2'h2, ~a);
      `CHK(drive_reduced, a[1])
      `CHK(termination_value, tv)
    end
    $display("test decode done");
    power_down = 1'b0;
    u_dmc_ctrl_model.load_reg(BANK_EXT, 13'h0000);
    // A load while the clock enable is low must leave everything frozen
    ce = 1'b0;
    u_dmc_ctrl_model.load_reg(BANK_EXT, 13'h0002);
    ce = 1'b1;
    step(2);
    `CHK(drive_reduced, 1'b0)
    odt_pin = 1'b0;
    sr_enter = 1'b1;
    step(1);
    sr_enter = 1'b0;
    step(2);
    `CHK(dll_enable, 1'b0)
    sr_exit = 1'b1;
    step(1);
    sr_exit = 1'b0;
    seen = 1'b0;
    repeat (4) begin
      if (dll_reset === 1'b1) seen = 1'b1;
      step(1);
    end
    `CHK(seen, 1'b1)
    `CHK(dll_enable, 1'b1)
    `CHK(rq.size() + wq.size() + iq.size() + jq.size(), 0)
    $display("test self refresh done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
